// ==== pkg/conv_pkg.sv ====
package conv_pkg;

    // ****************************************************************
    // Special function register map
    // ****************************************************************
    localparam logic [7:0] ADDR_ADC_RESULT  = 8'hc2;
    localparam logic [7:0] ADDR_ADC_CONTROL = 8'hc3;
    localparam logic [7:0] ADDR_DAC_VALUE   = 8'hc4;

    localparam logic [7:0] RESET_ADC_RESULT  = 8'h00;
    localparam logic [7:0] RESET_ADC_CONTROL = 8'h00;
    localparam logic [7:0] RESET_DAC_VALUE   = 8'h80;

    // Control register fields; bits 7 to 3 are reserved
    localparam int CTRL_REQUEST_BIT = 0;
    localparam int CTRL_CHANNEL_BIT = 1;
    localparam int CTRL_AUTO_BIT    = 2;
    localparam int CTRL_USED_BITS   = 3;

    // ****************************************************************
    // Converter shape
    // ****************************************************************
    localparam int ADC_BITS    = 8;
    localparam int ADC_STEP_MV = 8;
    localparam int ADC_FULL_MV = 2000;

    // ****************************************************************
    // Timing, clock at 10 MHz
    // ****************************************************************
    localparam int CLK_PERIOD_NS  = 100;
    localparam int ADC_MAX_MS     = 50;
    localparam int ADC_MAX_CYCLES = ADC_MAX_MS * 1000000 / CLK_PERIOD_NS;
    localparam int AUTO_PERIOD_MS = 30;
    localparam int AUTO_CYCLES    = AUTO_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
    localparam int DAC_MAX_US     = 25;
    localparam int DAC_MAX_CYCLES = DAC_MAX_US * 1000 / CLK_PERIOD_NS;

    // Analog settling allowed per generator step
    localparam int COMPARE_SETTLE_CYCLES = 16;
    localparam int DAC_SETTLE_CYCLES     = 16;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b001,
        ST_COMPARE = 3'b010,
        ST_DAC     = 3'b100
    } seq_state_type;

endpackage

// ==== core/sar_step.sv ====
`timescale 1ns/1ns

module sar_step
    import conv_pkg::*;
#(
    parameter int WIDTH = ADC_BITS
)
(
    input  wire logic             clk_in,    // System clock
    input  wire logic             rst_n_in,  // Synchronous reset, active low
    input  wire logic             start_in,  // Begin a conversion
    input  wire logic             abort_in,  // Drop a conversion in progress
    input  wire logic             strobe_in, // Comparator result is valid
    input  wire logic             above_in,  // Input at or above trial voltage
    output logic [WIDTH-1:0]      trial_out, // Trial code for the generator
    output logic [WIDTH-1:0]      final_out, // Code of the last conversion
    output logic                  busy_out,  // Conversion in progress
    output logic                  done_out   // One-cycle completion pulse
);

    logic [WIDTH-1:0] probe;

    if (WIDTH < 1)
    begin : g_width_check
        $error("sar_step needs at least one bit");
    end

    // ****************************************************************
    // Approximation register
    // ****************************************************************
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in || abort_in)
        begin
            trial_out <= '0;
            probe     <= '0;
            busy_out  <= 1'b0;
            done_out  <= 1'b0;
        end
        else
        begin
            done_out <= 1'b0;
            if (start_in)
            begin
                trial_out        <= '0;
                trial_out[WIDTH-1] <= 1'b1;                 // [R18]
                probe            <= '0;
                probe[WIDTH-1]   <= 1'b1;
                busy_out         <= 1'b1;
            end
            else if (strobe_in && busy_out)
            begin
                // Keep the trial bit only when the input reached it
                trial_out <= (trial_out & ~(probe & {WIDTH{~above_in}}))
                             | (probe >> 1);                // [R4] [R18]
                probe     <= probe >> 1;
                if (probe[0])
                begin
                    busy_out <= 1'b0;                       // [R5]
                    done_out <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            final_out <= '0;
        else if (strobe_in && busy_out && probe[0])
            final_out <= trial_out & ~(probe & {WIDTH{~above_in}});
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    int compare_tally;

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in || abort_in || start_in)
            compare_tally <= 0;
        else if (strobe_in && busy_out)
            compare_tally <= compare_tally + 1;
    end

    a_eight_compares: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R5]
        done_out |-> compare_tally == WIDTH)
        else $error("conversion did not take eight comparisons");

endmodule

// ==== core/sar_adc_dac_controller.sv ====
// How it works
// R1: Everything stops and stays idle while the chip is not in system-on mode.
// R2: Control bits choose the channel and request a conversion.
// R3: Hardware clears the request bit when the conversion completes.
// R4: The approximation register updates after every comparison.
// R5: A conversion ends after exactly eight comparisons.
// R6: Result register loads once at completion and holds still meanwhile.
// R7: Request to result takes well under 50 ms.
// R8: With the auto bit set a conversion starts every 30 ms.
// R9: Channel bit low selects input zero, high selects input one.
// R10: Software changes the channel only while no conversion runs.
// R11: Control bits 7 to 3 are reserved, read zero, ignore writes.
// R12: The 8-bit result register is read-only and resets to zero.
// R13: Result is linear unsigned code, 8 mV per step up to 2000 mV.
// R14: Control register sits at C3H and resets to zero.
// R15: Each write to the DAC value register starts a DAC update.
// R16: A DAC update completes in under 25 microseconds.
// R17: DAC value register sits at C4H and resets to mid-scale 80H.
// R18: Bits are decided MSB first, kept when input is at or above trial.
`timescale 1ns/1ns

module sar_adc_dac_controller
    import conv_pkg::*;
#(
    parameter int AUTO_PERIOD    = AUTO_CYCLES,
    parameter int COMPARE_SETTLE = COMPARE_SETTLE_CYCLES,
    parameter int DAC_SETTLE     = DAC_SETTLE_CYCLES
)
(
    input  wire logic       clk_in,           // 10 MHz clock
    input  wire logic       rst_n_in,         // Synchronous reset, active low
    input  wire logic       system_on_in,     // Chip in system-on mode
    input  wire logic [7:0] sfr_addr_in,      // Special function register address
    input  wire logic       sfr_wr_in,        // Register write strobe
    input  wire logic [7:0] sfr_wdata_in,     // Register write data
    input  wire logic       sfr_rd_in,        // Register read strobe
    output logic [7:0]      sfr_rdata_out,    // Read data, one cycle after strobe
    input  wire logic       comparator_in,    // Input at or above generated level
    output logic            channel_sel_out,  // Analog input mux select
    output logic            gen_enable_out,   // Voltage generator active
    output logic            gen_dac_phase_out,// Generator serves the DAC
    output logic [7:0]      gen_code_out,     // Code driven into the generator
    output logic            dac_load_out,     // One-cycle pulse: DAC output updates
    output logic            adc_busy_out      // Conversion in progress
);

    // ****************************************************************
    // Parameter checks
    // ****************************************************************
    localparam int CONV_CYCLES = ADC_BITS * (COMPARE_SETTLE + DAC_SETTLE + 4) + 4;

    if (AUTO_PERIOD < 1 || COMPARE_SETTLE < 1 || DAC_SETTLE < 1)
    begin : g_count_check
        $error("timing counts must be at least one cycle");
    end
    if (DAC_SETTLE + COMPARE_SETTLE + 4 >= DAC_MAX_CYCLES)
    begin : g_dac_check
        $error("DAC settle too long for the DAC update limit");
    end
    if (CONV_CYCLES >= ADC_MAX_CYCLES)                                  // [R7]
    begin : g_adc_check
        $error("compare settle too long for the conversion limit");
    end

    // ****************************************************************
    // Registers and sequencer state
    // ****************************************************************
    logic [7:0]    adc_result;
    logic          auto_conversion;
    logic          channel_select;
    logic          conversion_request;
    logic [7:0]    dac_value;
    logic          adc_pending;
    logic          dac_pending;
    logic [31:0]   auto_count;
    logic          auto_tick;
    logic [15:0]   settle_count;
    seq_state_type state;
    seq_state_type next_state;

    logic       wr_ctrl;
    logic       wr_dac;
    logic       settled;
    logic       sar_start;
    logic       sar_strobe;
    logic       sar_busy;
    logic       sar_done;
    logic [7:0] sar_trial;
    logic [7:0] sar_final;

    assign wr_ctrl    = sfr_wr_in && sfr_addr_in == ADDR_ADC_CONTROL;
    assign wr_dac     = sfr_wr_in && sfr_addr_in == ADDR_DAC_VALUE;
    assign settled    = settle_count == '0;
    assign sar_start  = state == ST_IDLE && system_on_in && !dac_pending && adc_pending;
    assign sar_strobe = state == ST_COMPARE && settled;

    sar_step #(
        .WIDTH     (ADC_BITS)
    ) u_approx (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .start_in  (sar_start),
        .abort_in  (!system_on_in),
        .strobe_in (sar_strobe),
        .above_in  (comparator_in),
        .trial_out (sar_trial),
        .final_out (sar_final),
        .busy_out  (sar_busy),
        .done_out  (sar_done)
    );

    // ****************************************************************
    // Control register
    // ****************************************************************
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            auto_conversion <= RESET_ADC_CONTROL[CTRL_AUTO_BIT];
            channel_select  <= RESET_ADC_CONTROL[CTRL_CHANNEL_BIT];
        end
        else if (wr_ctrl)
        begin
            auto_conversion <= sfr_wdata_in[CTRL_AUTO_BIT];     // [R2] [R8]
            channel_select  <= sfr_wdata_in[CTRL_CHANNEL_BIT];  // [R2] [R11]
        end
    end

    // A fresh request written in the completion cycle survives the clear
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            conversion_request <= RESET_ADC_CONTROL[CTRL_REQUEST_BIT];  // [R14]
        else if (wr_ctrl && sfr_wdata_in[CTRL_REQUEST_BIT])
            conversion_request <= 1'b1;                                 // [R2]
        else if (sar_done)
            conversion_request <= 1'b0;                                 // [R3]
        else if (wr_ctrl)
            conversion_request <= 1'b0;
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in || !system_on_in)
            adc_pending <= 1'b0;                                        // [R1]
        else if ((wr_ctrl && sfr_wdata_in[CTRL_REQUEST_BIT]) || auto_tick)
            adc_pending <= 1'b1;                                        // [R2] [R8]
        else if (sar_start)
            adc_pending <= 1'b0;
    end

    // ****************************************************************
    // Periodic conversion timer
    // ****************************************************************
    assign auto_tick = auto_conversion && system_on_in
                       && auto_count == 32'(AUTO_PERIOD - 1);

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in || !system_on_in || !auto_conversion)
            auto_count <= '0;
        else if (auto_tick)
            auto_count <= '0;                                           // [R8]
        else
            auto_count <= auto_count + 32'h1;
    end

    // ****************************************************************
    // Result and DAC value registers
    // ****************************************************************
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            adc_result <= RESET_ADC_RESULT;                             // [R12]
        else if (sar_done)
            adc_result <= sar_final;                                    // [R6] [R13]
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            dac_value <= RESET_DAC_VALUE;                               // [R17]
        else if (wr_dac)
            dac_value <= sfr_wdata_in;
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in || !system_on_in)
            dac_pending <= 1'b0;
        else if (wr_dac)
            dac_pending <= 1'b1;                                        // [R15]
        else if (state == ST_DAC && settled)
            dac_pending <= 1'b0;
    end

    // ****************************************************************
    // Register reads
    // ****************************************************************
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            sfr_rdata_out <= 8'h00;
        else if (sfr_rd_in)
        begin
            case (sfr_addr_in)
                ADDR_ADC_RESULT:  sfr_rdata_out <= adc_result;
                ADDR_ADC_CONTROL: sfr_rdata_out <= {5'h00, auto_conversion,
                                                    channel_select,
                                                    conversion_request};  // [R11]
                ADDR_DAC_VALUE:   sfr_rdata_out <= dac_value;
                default:          sfr_rdata_out <= 8'h00;
            endcase
        end
    end

    // ****************************************************************
    // Sequencer sharing the voltage generator
    // ****************************************************************
    // The DAC only waits for one comparison slot, which keeps its update
    // short even while a conversion runs.
    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:
                if (dac_pending)
                    next_state = ST_DAC;                                // [R15]
                else if (adc_pending)
                    next_state = ST_COMPARE;
            ST_COMPARE:
                if (sar_strobe && sar_trial != 8'h00 && dac_pending)
                    next_state = ST_DAC;
                else if (!sar_busy && !sar_start)
                    next_state = ST_IDLE;
            ST_DAC:
                if (settled)
                    next_state = sar_busy ? ST_COMPARE : ST_IDLE;       // [R16]
            default:
                next_state = ST_IDLE;
        endcase
        if (!system_on_in)
            next_state = ST_IDLE;                                       // [R1]
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            state <= ST_IDLE;
        else
            state <= next_state;
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in || state != next_state || sar_strobe)
            settle_count <= (next_state == ST_DAC) ? 16'(DAC_SETTLE)
                                                   : 16'(COMPARE_SETTLE);
        else if (!settled)
            settle_count <= settle_count - 16'h1;
    end

    // ****************************************************************
    // Generator and DAC outputs
    // ****************************************************************
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            gen_enable_out    <= 1'b0;
            gen_dac_phase_out <= 1'b0;
            gen_code_out      <= RESET_DAC_VALUE;
            dac_load_out      <= 1'b0;
        end
        else
        begin
            gen_enable_out    <= next_state != ST_IDLE;                 // [R1]
            gen_dac_phase_out <= next_state == ST_DAC;
            gen_code_out      <= (next_state == ST_DAC) ? dac_value : sar_trial;
            dac_load_out      <= state == ST_DAC && settled;            // [R16]
        end
    end

    assign channel_sel_out = channel_select;                            // [R9]
    assign adc_busy_out    = sar_busy;

    // ****************************************************************
    // Checks
    // ****************************************************************
    localparam int CONV_BOUND = 400;
    localparam int DAC_BOUND  = 250;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_conv_begins;
        sar_start ##1 sar_busy;
    endsequence
    // A power drop aborts the conversion, which then never completes
    sequence s_conv_ends;
        (sar_done ##1 (!conversion_request || $past(wr_ctrl))) or !system_on_in;
    endsequence
    a_result_holds: assert property (                                   // [R6]
        $changed(adc_result) |-> $past(sar_done))
        else $error("result register changed outside completion");
    a_request_cleared: assert property (                                // [R3]
        sar_done && !wr_ctrl |=> !conversion_request)
        else $error("request bit not cleared on completion");
    a_conv_bounded: assert property (                                   // [R7]
        s_conv_begins |-> ##[1:CONV_BOUND] s_conv_ends)
        else $error("conversion exceeded its time limit");
    a_msb_first: assert property (                                      // [R18]
        sar_start && system_on_in |=> sar_trial == 8'h80)
        else $error("conversion did not begin at the top bit");
    a_dac_update: assert property (                                     // [R15] [R16]
        wr_dac && system_on_in |-> ##[1:DAC_BOUND] (dac_load_out || !system_on_in))
        else $error("DAC write did not produce an update");
    a_off_idle: assert property (                                       // [R1]
        !system_on_in |=> state == ST_IDLE && !gen_enable_out)
        else $error("converter active outside system-on mode");
    a_auto_start: assert property (                                     // [R8]
        auto_tick |=> adc_pending || sar_busy)
        else $error("periodic conversion not started");
    a_reserved_zero: assert property (                                  // [R11]
        $past(sfr_rd_in) && $past(sfr_addr_in) == ADDR_ADC_CONTROL
        |-> sfr_rdata_out[7:CTRL_USED_BITS] == 5'h00)
        else $error("reserved control bits read non-zero");
    a_channel_map: assert property (                                    // [R9]
        $past(wr_ctrl) |-> channel_sel_out == $past(sfr_wdata_in[CTRL_CHANNEL_BIT]))
        else $error("channel select not routed to the mux");
endmodule

// ==== testbench/analog_front_model.sv ====
`timescale 1ns/1ns

module analog_front_model
(
    input  wire logic        clk_in,        // System clock
    input  wire logic        gen_enable_in, // Generator in use
    input  wire logic        dac_phase_in,  // Generator serves the DAC
    input  wire logic [7:0]  code_in,       // Generator code
    input  wire logic        channel_in,    // Input mux select
    input  wire logic [11:0] zero_mv_in,    // Level on input zero, mV
    input  wire logic [11:0] one_mv_in,     // Level on input one, mV
    output logic             above_out      // Input at or above generated level
);
    logic        junk = 1'b0;
    logic [11:0] level_mv;

    // Outside a comparison the output is noise, never a stale answer
    always @(posedge clk_in)
        junk <= ~junk;

    assign level_mv  = channel_in ? one_mv_in : zero_mv_in;
    assign above_out = (gen_enable_in && !dac_phase_in)
                     ? (level_mv >= {1'b0, code_in, 3'b000}) : junk;
endmodule

// ==== testbench/testbench.sv ====
`timescale 1ns/1ns

module testbench;
    import conv_pkg::*;

    localparam int AUTO_SIM = 400;
    localparam int LIMIT    = 20000;

    typedef struct {
        logic        ch;
        logic [11:0] mv0;
        logic [11:0] mv1;
        logic [7:0]  res;
    } row_type;

    row_type rows [6] = '{'{1'b0, 12'h000, 12'h7d0, 8'h00}, '{1'b1, 12'h000, 12'h7d0, 8'hfa},
                          '{1'b0, 12'h3e8, 12'h007, 8'h7d}, '{1'b1, 12'h3e8, 12'h007, 8'h00},
                          '{1'b0, 12'h7ff, 12'h008, 8'hff}, '{1'b1, 12'h7ff, 12'h008, 8'h01}};

    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        sys_on = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic        wr = 1'b0;
    logic [7:0]  wdata = 8'h00;
    logic        rd = 1'b0;
    logic [7:0]  rdata;
    logic        comp;
    logic        chan;
    logic        gen_en;
    logic        gen_dac;
    logic [7:0]  gen_code;
    logic        dac_load;
    logic        busy;
    logic [11:0] mv0 = 12'h000;
    logic [11:0] mv1 = 12'h000;
    int          num_errors = 0;
    int          checked = 0;
    int          ticks = 0;

    always #50 clk = ~clk;

    sar_adc_dac_controller #(.AUTO_PERIOD(AUTO_SIM), .COMPARE_SETTLE(2), .DAC_SETTLE(2)) dut_u (
        .clk_in(clk), .rst_n_in(rst_n), .system_on_in(sys_on), .sfr_addr_in(addr),
        .sfr_wr_in(wr), .sfr_wdata_in(wdata), .sfr_rd_in(rd), .sfr_rdata_out(rdata),
        .comparator_in(comp), .channel_sel_out(chan), .gen_enable_out(gen_en),
        .gen_dac_phase_out(gen_dac), .gen_code_out(gen_code),
        .dac_load_out(dac_load), .adc_busy_out(busy));

    analog_front_model model_u (
        .clk_in(clk), .gen_enable_in(gen_en), .dac_phase_in(gen_dac),
        .code_in(gen_code), .channel_in(chan), .zero_mv_in(mv0),
        .one_mv_in(mv1), .above_out(comp));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        d = rdata;
    endtask

    task automatic wait_done(output int n);
        n = 0;
        while (busy !== 1'b1 && n < 10)
        begin
            @(negedge clk);
            n++;
        end
        while (busy === 1'b1 && n < ADC_MAX_CYCLES)
        begin
            @(negedge clk);
            n++;
        end
        repeat (2) @(negedge clk);
    endtask

    task automatic report_and_stop;
        $display("Comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    always @(posedge clk)
    begin
        ticks++;
        if (ticks == LIMIT)
        begin
            num_errors++;
            report_and_stop();
        end
    end

    // ****************************************************************
    // Sequence
    // ****************************************************************
    initial
    begin
        logic [7:0] d;
        logic [7:0] prev;
        logic [7:0] exp;
        int         n;
        int         seen;
        prev = RESET_ADC_RESULT;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        foreach (rows[i])
        begin
            mv0 = rows[i].mv0;
            mv1 = rows[i].mv1;
            exp = rows[i].res;
            reg_write(ADDR_ADC_CONTROL, {6'h00, rows[i].ch, 1'b1});
            check("channel select", rows[i].ch, chan);
            reg_read(ADDR_ADC_RESULT, d);
            check("result mid conversion", prev, d);
            wait_done(n);
            check("conversion time in range", 1, n > 10 && n < ADC_MAX_CYCLES);
            reg_read(ADDR_ADC_RESULT, d);
            check("result", exp, d);
            reg_read(ADDR_ADC_CONTROL, d);
            check("request cleared", {6'h00, rows[i].ch, 1'b0}, d);
            prev = exp;
            $display("Row %0d done", i);
        end
        // DAC write landing in mid-conversion
        mv0 = 12'h3e8;
        reg_write(ADDR_ADC_CONTROL, 8'h01);
        reg_write(ADDR_DAC_VALUE, 8'h5a);
        n = 0;
        // The code leaves the generator as the load pulse rises, so keep it from the phase
        while (dac_load !== 1'b1 && n < DAC_MAX_CYCLES)
        begin
            @(negedge clk);
            n++;
            if (gen_dac === 1'b1)
                d = gen_code;
        end
        check("dac load in time", 1, n < DAC_MAX_CYCLES);
        check("dac code", 8'h5a, d);
        wait_done(n);
        reg_read(ADDR_ADC_RESULT, d);
        check("result beside dac", 8'h7d, d);
        reg_read(ADDR_DAC_VALUE, d);
        check("dac readback", 8'h5a, d);
        $display("Dac test done");
        // Automatic conversions
        reg_write(ADDR_ADC_CONTROL, 8'h04);
        @(posedge busy);
        n = ticks;
        @(posedge busy);
        n = ticks - n;
        check("auto period", 1, n >= AUTO_SIM - 2 && n <= AUTO_SIM + 2);
        reg_write(ADDR_ADC_CONTROL, 8'h00);
        wait_done(n);
        $display("Auto test done");
        // Power mode off
        sys_on = 1'b0;
        seen = 0;
        reg_write(ADDR_ADC_CONTROL, 8'h01);
        reg_write(ADDR_DAC_VALUE, 8'h11);
        repeat (60)
        begin
            @(negedge clk);
            if (busy !== 1'b0 || dac_load !== 1'b0 || gen_en !== 1'b0)
                seen = 1;
        end
        check("idle when off", 0, seen);
        sys_on = 1'b1;
        reg_write(ADDR_ADC_CONTROL, 8'h00);
        repeat (4) @(negedge clk);
        $display("Power test done");
        // Second reset, then register map edges
        rst_n = 1'b0;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        reg_read(ADDR_ADC_RESULT, d);
        check("result reset", RESET_ADC_RESULT, d);
        reg_read(ADDR_ADC_CONTROL, d);
        check("control reset", RESET_ADC_CONTROL, d);
        reg_read(ADDR_DAC_VALUE, d);
        check("dac reset", RESET_DAC_VALUE, d);
        reg_write(ADDR_ADC_CONTROL, 8'hf8);
        reg_read(ADDR_ADC_CONTROL, d);
        check("reserved bits", 8'h00, d);
        reg_write(ADDR_ADC_RESULT, 8'h33);
        reg_read(ADDR_ADC_RESULT, d);
        check("result read only", 8'h00, d);
        reg_read(8'h55, d);
        check("unmapped read", 8'h00, d);
        $display("Register test done");
        report_and_stop();
    end
endmodule
